// >>> rtl/fgen_pkg.sv
// package: constants and carriers for the t1/j1 frame generator
package fgen_pkg;
   // register index on reg_addr
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_INV  = 4'h1;
   localparam logic [3:0] REG_STAT = 4'h2;
   // control fields
   localparam int C_FRAMING_DISABLE   = 0;
   localparam int C_CRC_INSERT_BYPASS = 1;
   localparam int C_DLBYP  = 2;
   localparam int C_MIMIC  = 3;
   localparam int C_MANUAL_YELLOW_SEND   = 4;
   localparam int C_AUTOY  = 5;
   localparam int C_J1     = 6;
   localparam int C_FMT    = 7;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   // one-shot invert fields
   localparam int I_FT  = 0;
   localparam int I_FS  = 1;
   localparam int I_CRC = 2;
   localparam int I_DDS = 3;
   // status fields
   localparam int S_YEL = 0;
   localparam int S_RED = 1;
   localparam int S_FR  = 8;
   // formats
   localparam logic [1:0] FMT_SF  = 2'h0;
   localparam logic [1:0] FMT_ESF = 2'h1;
   localparam logic [1:0] FMT_DM  = 2'h2;
   // frame geometry
   localparam logic [7:0] LAST_BIT  = 8'hc0;
   localparam logic [7:0] CH24_BIT  = 8'hb9;
   localparam logic [4:0] SF_LAST   = 5'h0b;
   localparam logic [4:0] ESF_LAST  = 5'h17;
   // patterns
   localparam logic [11:0] SF_PAT  = 12'h8dc;
   localparam logic [5:0]  ESF_FAS = 6'h0b;
   localparam logic [7:0]  DDS_PAT = 8'h1d;
   localparam logic [15:0] YEL_T1  = 16'hff00;
   localparam logic [15:0] ONES    = 16'hffff;
   localparam logic [15:0] IDLE_J1 = 16'hff7e;
   localparam logic [5:0]  CRC_POLY = 6'h03;
   // stream bit and data-link source carriers
   typedef struct packed {logic valid; logic data;} fgen_bit_t;
   typedef struct packed {logic req; logic data;} fgen_src_t;
endpackage : fgen_pkg

// >>> rtl/fgen_gen.sv
// module: t1/j1 transmit frame generator with register port
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - sf, esf or t1-only dm framing unless disabled
// - sf f-bits carry 12-frame alignment pattern
// - j1 sf frame 12 f-bit zero unless yellow
// - one-shot invert of one ft or fs bit
// - mimic copies f-bit into next bit
// - yellow from manual bit or auto on red
// - t1 sf yellow zeroes bit 2 each channel
// - j1 sf yellow is one in f-bit 12
// - esf frames 4n carry 001011
// - esf one-shot invert of one alignment bit
// - esf crc-6 of previous superframe inserted
// - one-shot invert of a whole crc pattern
// - data link filled by source priority
// - non-yellow link sources need bypass off
// - idle code ffff t1, ff7e j1
// - esf yellow pattern ff00 t1, ffff j1
// - dm f-bits carry 100011011100
// - dm channel 24 carries dds pattern
// - one-shot invert of one dds pattern
// - dm channel 24 bit 7 carries hdlc
// - dm yellow zero in ch24 bit 6
//////////////////////////////////////////////////////////////////////////////
module fgen_gen (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // register port
   input  wire logic [3:0]          reg_addr,
   input  wire logic [15:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [15:0]              reg_rdata_q,
   // payload stream
   input  wire fgen_pkg::fgen_bit_t in_s,
   output fgen_pkg::fgen_bit_t      out_q,
   output logic                     mf_start_q,
   // receive path alarm
   input  wire logic                red_alarm,
   // data-link sources
   input  wire fgen_pkg::fgen_src_t boc_src,
   input  wire fgen_pkg::fgen_src_t prm_src,
   input  wire fgen_pkg::fgen_src_t hdlc_src,
   output logic [2:0]               dl_take_q
);
   //////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic pat16(input logic [15:0] p, input logic [3:0] i);
      return p[4'hf - i];
   endfunction : pat16

   function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
      return {c[4:0], 1'b0} ^ ((b ^ c[5]) ? fgen_pkg::CRC_POLY : 6'h00);
   endfunction : crc_step

   logic [15:0] ctrl_q;
   logic        ft_pend_q, fs_pend_q, crc_pend_q, dds_pend_q;
   logic        crc_act_q, dds_act_q;
   logic [7:0]  bit_q;
   logic [4:0]  fr_q;
   logic [3:0]  dl_idx_q;
   logic [5:0]  crc_acc_q, crc_prev_q;
   logic        f_q;
   logic        red1_q, red2_q, red3_q, red_q;

   logic        framing_disable, j1, yel, is_f, ch24, mf_last;
   logic [1:0]  fmt;
   logic [2:0]  off, k;
   logic [3:0]  fr_lo;
   logic [4:0]  mf_end;
   logic        o, ft_use, fs_use, crc_start, dds_start, dl_adv, inv_wr;
   logic [2:0]  take;

   assign framing_disable   = ctrl_q[fgen_pkg::C_FRAMING_DISABLE];
   assign j1     = ctrl_q[fgen_pkg::C_J1];
   assign fmt    = (ctrl_q[fgen_pkg::C_FMT +: 2] == fgen_pkg::FMT_DM && !j1) ?
                   fgen_pkg::FMT_DM :
                   (ctrl_q[fgen_pkg::C_FMT +: 2] == fgen_pkg::FMT_ESF) ?
                   fgen_pkg::FMT_ESF : fgen_pkg::FMT_SF;
   assign yel    = ctrl_q[fgen_pkg::C_MANUAL_YELLOW_SEND] |
                   (ctrl_q[fgen_pkg::C_AUTOY] & red_q);
   assign is_f   = (bit_q == 8'h00);
   assign off    = 3'(bit_q - 8'h01);
   assign ch24   = (bit_q >= fgen_pkg::CH24_BIT);
   assign k      = 3'(bit_q - fgen_pkg::CH24_BIT);
   assign fr_lo  = fr_q[3:0];
   assign mf_end = (fmt == fgen_pkg::FMT_ESF) ? fgen_pkg::ESF_LAST : fgen_pkg::SF_LAST;
   assign mf_last = (bit_q == fgen_pkg::LAST_BIT) && (fr_q >= mf_end);
   assign inv_wr = reg_wr && (reg_addr == fgen_pkg::REG_INV);

   //////////////////////////////////////////////////////////////////////////
   // overhead insertion
   always_comb begin
      o         = in_s.data;
      ft_use    = 1'b0;
      fs_use    = 1'b0;
      crc_start = 1'b0;
      dds_start = 1'b0;
      dl_adv    = 1'b0;
      take      = 3'h0;
      if (!framing_disable) begin
         case (fmt)
            fgen_pkg::FMT_ESF: begin
               if (is_f && fr_q[1:0] == 2'h3) begin
                  o      = fgen_pkg::ESF_FAS[3'h5 - fr_q[4:2]] ^ fs_pend_q;
                  fs_use = fs_pend_q;
               end else if (is_f && fr_q[1:0] == 2'h1) begin
                  if (!ctrl_q[fgen_pkg::C_CRC_INSERT_BYPASS]) begin
                     crc_start = (fr_q == 5'h01) && crc_pend_q;
                     o = crc_prev_q[3'h5 - fr_q[4:2]] ^
                         (crc_act_q | crc_start);
                  end
               end else if (is_f) begin
                  dl_adv = 1'b1;
                  if (yel) begin
                     o = pat16(j1 ? fgen_pkg::ONES : fgen_pkg::YEL_T1,
                               dl_idx_q);
                  end else if (!ctrl_q[fgen_pkg::C_DLBYP]) begin
                     if (boc_src.req) begin
                        o    = boc_src.data;
                        take = 3'h1;
                     end else if (prm_src.req) begin
                        o    = prm_src.data;
                        take = 3'h2;
                     end else if (hdlc_src.req) begin
                        o    = hdlc_src.data;
                        take = 3'h4;
                     end else begin
                        o = pat16(j1 ? fgen_pkg::IDLE_J1 : fgen_pkg::ONES,
                                  dl_idx_q);
                     end
                  end
               end
            end
            fgen_pkg::FMT_DM: begin
               if (is_f) begin
                  o = fgen_pkg::SF_PAT[4'hb - fr_lo];
                  if (!fr_q[0]) begin
                     o      = o ^ ft_pend_q;
                     ft_use = ft_pend_q;
                  end else begin
                     o      = o ^ fs_pend_q;
                     fs_use = fs_pend_q;
                  end
               end else if (ch24) begin
                  dds_start = (k == 3'h0) && dds_pend_q;
                  if (k == 3'h5) begin
                     o = !yel;
                  end else if (k == 3'h6) begin
                     if (!ctrl_q[fgen_pkg::C_DLBYP] && hdlc_src.req) begin
                        o    = hdlc_src.data;
                        take = 3'h4;
                     end
                  end else begin
                     o = fgen_pkg::DDS_PAT[k] ^ (dds_act_q | dds_start);
                  end
               end
            end
            default: begin
               if (is_f) begin
                  o = fgen_pkg::SF_PAT[4'hb - fr_lo];
                  if (j1 && fr_q == 5'h0b) begin
                     o = yel;
                  end
                  if (!fr_q[0]) begin
                     o      = o ^ ft_pend_q;
                     ft_use = ft_pend_q;
                  end else begin
                     o      = o ^ fs_pend_q;
                     fs_use = fs_pend_q;
                  end
               end else if (!j1 && yel && off == 3'h1) begin
                  o = 1'b0;
               end
            end
         endcase
         if (ctrl_q[fgen_pkg::C_MIMIC] && bit_q == 8'h01) begin
            o = f_q;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // output stream
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_q      <= '0;
         mf_start_q <= 1'b0;
         dl_take_q  <= 3'h0;
         f_q        <= 1'b0;
      end else begin
         out_q.valid <= in_s.valid;
         out_q.data  <= in_s.valid ? o : out_q.data;
         mf_start_q  <= in_s.valid && is_f && fr_q == 5'h00;
         dl_take_q   <= in_s.valid ? take : 3'h0;
         if (in_s.valid && is_f) begin
            f_q <= o;
         end
      end
   end

   // frame position counters
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_q    <= 8'h00;
         fr_q     <= 5'h00;
         dl_idx_q <= 4'h0;
      end else if (in_s.valid) begin
         bit_q <= (bit_q == fgen_pkg::LAST_BIT) ? 8'h00 : bit_q + 8'h01;
         if (bit_q == fgen_pkg::LAST_BIT) begin
            fr_q <= mf_last ? 5'h00 : fr_q + 5'h01;
         end
         if (dl_adv) begin
            dl_idx_q <= dl_idx_q + 4'h1;
         end
      end
   end

   // crc-6 over each superframe, f-bits counted as one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         crc_acc_q  <= 6'h00;
         crc_prev_q <= 6'h00;
      end else if (in_s.valid) begin
         if (mf_last) begin
            crc_acc_q  <= 6'h00;
            crc_prev_q <= crc_step(crc_acc_q, o);
         end else begin
            crc_acc_q <= crc_step(crc_acc_q, is_f | o);
         end
      end
   end

   // one-shot invert requests; a software set wins over consumption
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ft_pend_q  <= 1'b0;
         fs_pend_q  <= 1'b0;
         crc_pend_q <= 1'b0;
         dds_pend_q <= 1'b0;
         crc_act_q  <= 1'b0;
         dds_act_q  <= 1'b0;
      end else begin
         ft_pend_q  <= (inv_wr && reg_wdata[fgen_pkg::I_FT]) ||
                       (ft_pend_q && !(in_s.valid && ft_use));
         fs_pend_q  <= (inv_wr && reg_wdata[fgen_pkg::I_FS]) ||
                       (fs_pend_q && !(in_s.valid && fs_use));
         crc_pend_q <= (inv_wr && reg_wdata[fgen_pkg::I_CRC]) ||
                       (crc_pend_q && !(in_s.valid && crc_start));
         dds_pend_q <= (inv_wr && reg_wdata[fgen_pkg::I_DDS]) ||
                       (dds_pend_q && !(in_s.valid && dds_start));
         if (in_s.valid && crc_start) begin
            crc_act_q <= 1'b1;
         end else if (in_s.valid && (fr_q == 5'h15 && is_f || framing_disable)) begin
            crc_act_q <= 1'b0;
         end
         if (in_s.valid && dds_start) begin
            dds_act_q <= 1'b1;
         end else if (in_s.valid && (bit_q == fgen_pkg::LAST_BIT || framing_disable)) begin
            dds_act_q <= 1'b0;
         end
      end
   end

   // red alarm synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         red1_q <= 1'b0;
         red2_q <= 1'b0;
         red3_q <= 1'b0;
         red_q  <= 1'b0;
      end else begin
         red1_q <= red_alarm;
         red2_q <= red1_q;
         red3_q <= red2_q;
         if (red2_q == red3_q) begin
            red_q <= red3_q;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // register port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q      <= fgen_pkg::CTRL_RST;
         reg_rdata_q <= 16'h0000;
      end else begin
         if (reg_wr && reg_addr == fgen_pkg::REG_CTRL) begin
            ctrl_q <= {7'h00, reg_wdata[8:0]};
         end
         reg_rdata_q <= 16'h0000;
         if (reg_rd) begin
            case (reg_addr)
               fgen_pkg::REG_CTRL: reg_rdata_q <= ctrl_q;
               fgen_pkg::REG_INV:  reg_rdata_q <= {12'h000, dds_pend_q, crc_pend_q,
                                                   fs_pend_q, ft_pend_q};
               fgen_pkg::REG_STAT: reg_rdata_q <= {3'h0, fr_q, 6'h00, red_q, yel};
               default:            reg_rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic act_v;
   assign act_v = in_s.valid && !framing_disable;

   pass_through_a: assert property (
      in_s.valid && framing_disable |=> out_q.data == $past(in_s.data))
      else $error("stream altered while framing disabled");
   sf_align_a: assert property (
      act_v && fmt == fgen_pkg::FMT_SF && !j1 && is_f && !ft_pend_q && !fs_pend_q
      |=> out_q.data == fgen_pkg::SF_PAT[4'hb - $past(fr_lo)])
      else $error("sf alignment bit wrong");
   j1_f12_a: assert property (
      act_v && fmt == fgen_pkg::FMT_SF && j1 && is_f && fr_q == 5'h0b && !fs_pend_q
      |=> out_q.data == $past(yel))
      else $error("j1 frame 12 f-bit wrong");
   t1_yellow_a: assert property (
      act_v && fmt == fgen_pkg::FMT_SF && !j1 && yel && off == 3'h1 && bit_q != 8'h01
      |=> !out_q.data)
      else $error("t1 sf yellow bit not zero");
   esf_fas_a: assert property (
      act_v && fmt == fgen_pkg::FMT_ESF && is_f && fr_q[1:0] == 2'h3 && !fs_pend_q
      |=> out_q.data == fgen_pkg::ESF_FAS[3'h5 - $past(fr_q[4:2])])
      else $error("esf alignment bit wrong");
   dm_yellow_a: assert property (
      act_v && fmt == fgen_pkg::FMT_DM && ch24 && k == 3'h5 |=> out_q.data == !$past(yel))
      else $error("dm yellow bit wrong");
   mimic_bit_a: assert property (
      act_v && ctrl_q[fgen_pkg::C_MIMIC] && bit_q == 8'h01 |=> out_q.data == $past(f_q))
      else $error("mimic bit differs from f-bit");
   inv_once_a: assert property (
      in_s.valid && ft_use && !inv_wr |=> !ft_pend_q)
      else $error("terminal invert not consumed");
   ft_flip_a: assert property (
      act_v && ft_use |=> out_q.data != fgen_pkg::SF_PAT[4'hb - $past(fr_lo)])
      else $error("terminal bit not inverted");
   esf_yellow_a: assert property (
      act_v && fmt == fgen_pkg::FMT_ESF && yel && is_f && !fr_q[0]
      |=> out_q.data == pat16($past(j1) ? fgen_pkg::ONES : fgen_pkg::YEL_T1, $past(dl_idx_q)))
      else $error("esf yellow pattern wrong");
   dm_dds_a: assert property (
      act_v && fmt == fgen_pkg::FMT_DM && ch24 && k == 3'h7 && !dds_act_q |=> !out_q.data)
      else $error("dds bit 8 wrong");
   dds_flip_a: assert property (
      act_v && fmt == fgen_pkg::FMT_DM && ch24 && k == 3'h7 && dds_act_q |=> out_q.data)
      else $error("dds bit 8 not inverted");
   crc_bypass_a: assert property (
      act_v && fmt == fgen_pkg::FMT_ESF && is_f && fr_q[1:0] == 2'h1 &&
      ctrl_q[fgen_pkg::C_CRC_INSERT_BYPASS] |=> out_q.data == $past(in_s.data))
      else $error("crc position altered in bypass");
   crc_flip_a: assert property (
      act_v && crc_start |=> out_q.data != $past(crc_prev_q[5]))
      else $error("first crc bit not inverted");
   dl_prio_a: assert property (
      act_v && fmt == fgen_pkg::FMT_ESF && is_f && !fr_q[0] && !yel &&
      !ctrl_q[fgen_pkg::C_DLBYP] && boc_src.req
      |=> dl_take_q == 3'h1 && out_q.data == $past(boc_src.data))
      else $error("code source not given priority");
   dl_bypass_a: assert property (
      act_v && fmt == fgen_pkg::FMT_ESF && is_f && !fr_q[0] && !yel &&
      ctrl_q[fgen_pkg::C_DLBYP] |=> dl_take_q == 3'h0 && out_q.data == $past(in_s.data))
      else $error("data link replaced in bypass");
   esf_idle_a: assert property (
      act_v && fmt == fgen_pkg::FMT_ESF && is_f && !fr_q[0] && !yel &&
      !ctrl_q[fgen_pkg::C_DLBYP] && !boc_src.req && !prm_src.req && !hdlc_src.req
      |=> out_q.data == pat16($past(j1) ? fgen_pkg::IDLE_J1 : fgen_pkg::ONES, $past(dl_idx_q)))
      else $error("idle code wrong");
   dm_hdlc_a: assert property (
      act_v && fmt == fgen_pkg::FMT_DM && ch24 && k == 3'h6 && !ctrl_q[fgen_pkg::C_DLBYP] &&
      hdlc_src.req |=> dl_take_q == 3'h4 && out_q.data == $past(hdlc_src.data))
      else $error("dm link bit not from hdlc");

   sf_mf_c:  cover property (act_v && fmt == fgen_pkg::FMT_SF && mf_last);
   esf_crc_c: cover property (act_v && crc_start);
   dm_ch24_c: cover property (act_v && fmt == fgen_pkg::FMT_DM && dds_start);
   esf_boc_c: cover property (act_v && take == 3'h1);
   dm_yel_c:  cover property (act_v && fmt == fgen_pkg::FMT_DM && yel && ch24 && k == 3'h5);
endmodule : fgen_gen

// >>> tb/fgen_pay_src.sv
// partner model: payload bit source feeding the frame generator
`timescale 1ns/1ps
module fgen_pay_src (
   // clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // pacing
   input  wire logic           run,
   input  wire logic           slow,
   // stream to generator
   output fgen_pkg::fgen_bit_t in_s
);
   logic ph_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_q <= 1'b0;
         in_s <= '0;
      end else begin
         ph_q <= ~ph_q;
         in_s.valid <= run && (!slow || ph_q);
         // gaps invert the data every cycle
         in_s.data <= (run && (!slow || ph_q)) ? 1'b1 : ~in_s.data;
      end
   end
endmodule : fgen_pay_src

// >>> tb/tb.sv
// testbench: scenarios for the t1/j1 frame generator
`timescale 1ns/1ps
module tb;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic [3:0]          reg_addr = '0;
   logic [15:0]         reg_wdata = '0;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [15:0]         reg_rdata_q;
   fgen_pkg::fgen_bit_t in_s;
   fgen_pkg::fgen_bit_t out_q;
   logic                mf_start_q;
   logic                red_alarm = 1'b0;
   fgen_pkg::fgen_src_t boc = '0;
   fgen_pkg::fgen_src_t prm = '0;
   fgen_pkg::fgen_src_t hdlc = '0;
   logic [2:0]          dl_take_q;
   logic                run = 1'b0;
   logic                slow = 1'b0;
   logic                obit [24][193];
   int                  opos, ofr, ntake, nmf, cyc, n_errors, num_checks;
   always #5 clk = ~clk;
   fgen_pay_src i_src (.clk(clk), .rst(rst), .run(run), .slow(slow), .in_s(in_s));
   fgen_gen i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .in_s(in_s),
      .out_q(out_q), .mf_start_q(mf_start_q), .red_alarm(red_alarm), .boc_src(boc),
      .prm_src(prm), .hdlc_src(hdlc), .dl_take_q(dl_take_q));
   //////////////////////////////////////////////////////////////////////////////
   // output capture by frame and bit position
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         n_errors++;
         complete_run();
      end else if (rst) begin
         opos <= 0;
         ofr <= 0;
         ntake <= 0;
         nmf <= 0;
      end else begin
         if (out_q.valid) begin
            if (ofr < 24) obit[ofr][opos] <= out_q.data;
            opos <= (opos == 192) ? 0 : opos + 1;
            if (opos == 192) ofr <= ofr + 1;
            if (mf_start_q && ofr < 24) nmf <= nmf + ((opos == 0) ? 1 : 100);
         end
         if (dl_take_q != 3'h0 && ofr < 24) ntake <= ntake + int'(dl_take_q);
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata_q;
   endtask : rd
   task automatic rst_dut;
      @(posedge clk);
      rst <= 1'b1;
      run <= 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
   endtask : rst_dut
   task automatic go(input logic [15:0] ctrl, input logic [15:0] inv, input logic s);
      int i;
      rst_dut();
      wr(4'h0, ctrl);
      if (inv != 16'h0000) wr(4'h1, inv);
      @(posedge clk);
      run <= 1'b1;
      slow <= s;
      i = 0;
      while (ofr < 24 && i < 20000) begin
         @(posedge clk);
         i++;
      end
      run <= 1'b0;
      chk("frames", 24'(ofr), 24'h00_0018);
      chk("mf_starts", 24'(nmf), (ctrl[8:7] == 2'h1) ? 24'h00_0001 : 24'h00_0002);
   endtask : go
   function automatic logic [23:0] fcol(input int p);
      logic [23:0] v;
      for (int f = 0; f < 24; f++) v[23-f] = obit[f][p];
      return v;
   endfunction : fcol
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   //////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_regs;
      logic [15:0] v;
      rst_dut();
      rd(4'h0, v);
      chk("ctrl_rst", 24'(v), 24'h00_0000);
      wr(4'h0, 16'hffff);
      rd(4'h0, v);
      chk("ctrl_rw", 24'(v), 24'h00_01ff);
      rd(4'h7, v);
      chk("unmapped", 24'(v), 24'h00_0000);
      wr(4'h1, 16'h000f);
      rd(4'h1, v);
      chk("inv_set", 24'(v), 24'h00_000f);
   endtask : t_regs
   task automatic t_passthru;
      go(16'h0019, 16'h0003, 1'b0);
      chk("pt_fbit", fcol(0), 24'hff_ffff);
      chk("pt_mimic", fcol(1), 24'hff_ffff);
      chk("pt_bit2", fcol(2), 24'hff_ffff);
   endtask : t_passthru
   task automatic t_yellow;
      logic [15:0] v;
      logic [23:0] e;
      for (int m = 0; m < 3; m++) begin
         red_alarm <= (m == 1);
         e = (m == 2) ? 24'hff_ffff : 24'h00_0000;
         go((m == 0) ? 16'h0010 : ((m == 1) ? 16'h0020 : 16'h0028), 16'h0000, m == 1);
         chk("yel_ch1", fcol(2), e);
         chk("yel_ch24", fcol(186), e);
         chk("yel_bit3", fcol(3), 24'hff_ffff);
         rd(4'h2, v);
         chk("yel_stat", 24'(v[0]), 24'(m != 2));
         if (m == 2) chk("mimic", fcol(1), fcol(0));
      end
      red_alarm <= 1'b0;
   endtask : t_yellow
   task automatic t_j1;
      for (int y = 0; y < 2; y++) begin
         go((y == 1) ? 16'h0050 : 16'h0040, 16'h0000, 1'b0);
         chk("j1_fbit", fcol(0), (y == 1) ? {12'h8dd, 12'h8dd} : {12'h8dc, 12'h8dc});
         chk("j1_bit2", fcol(2), 24'hff_ffff);
      end
   endtask : t_j1
   task automatic t_invert;
      logic [23:0] d;
      logic [15:0] v;
      for (int k = 0; k < 3; k++) begin
         go((k == 2) ? 16'h0100 : 16'h0000, (k == 1) ? 16'h0002 : 16'h0001, 1'b0);
         d = fcol(0) ^ {12'h8dc, 12'h8dc};
         chk("inv_count", 24'($countones(d)), 24'h00_0001);
         chk("inv_frame", 24'((d & ((k == 1) ? 24'h55_5555 : 24'haa_aaaa)) != 0), 24'h00_0001);
         rd(4'h1, v);
         chk("inv_used", 24'(v), 24'h00_0000);
         chk("payload", fcol(100), 24'hff_ffff);
      end
   endtask : t_invert
   task automatic t_esf;
      logic [15:0] c [5] = '{16'h0080, 16'h00c0, 16'h0090, 16'h0080, 16'h0086};
      logic [11:0] e [5] = '{12'hfff, 12'hff7, 12'hff0, 12'h000, 12'hfff};
      logic [23:0] v;
      logic [11:0] dl;
      logic [5:0]  fa;
      logic [5:0]  cr;
      for (int k = 0; k < 5; k++) begin
         boc <= '{req: (k > 1), data: 1'b0};
         go(c[k], (k == 0) ? 16'h0006 : 16'h0000, 1'b0);
         v = fcol(0);
         fa = {v[20], v[16], v[12], v[8], v[4], v[0]};
         cr = {v[22], v[18], v[14], v[10], v[6], v[2]};
         chk("esf_crc", 24'(cr), (k == 0 || k == 4) ? 24'h00_003f : 24'h00_0000);
         for (int j = 0; j < 12; j++) dl[11-j] = v[23-2*j];
         chk("esf_dl", 24'(dl), 24'(e[k]));
         chk("esf_take", 24'(ntake), (k == 3) ? 24'h00_000c : 24'h00_0000);
         chk("esf_fas", 24'($countones(fa ^ 6'h0b)), 24'(k == 0));
      end
      boc <= '0;
   endtask : t_esf
   task automatic t_dm;
      logic [5:0] p;
      int         nd;
      hdlc <= '{req: 1'b1, data: 1'b0};
      for (int y = 0; y < 2; y++) begin
         go((y == 1) ? 16'h0110 : 16'h0100, (y == 1) ? 16'h0000 : 16'h0008, 1'b0);
         nd = 0;
         for (int f = 0; f < 24; f++) begin
            p = {obit[f][192], obit[f][189], obit[f][188], obit[f][187], obit[f][186],
                 obit[f][185]};
            if (p !== 6'h1d) begin
               nd++;
               chk("dds_inv", 24'(p), 24'h00_0022);
            end
         end
         chk("dds_count", 24'(nd), 24'(y == 0));
         chk("dm_fbit", fcol(0), {12'h8dc, 12'h8dc});
         chk("dm_yellow", fcol(190), (y == 1) ? 24'h00_0000 : 24'hff_ffff);
         chk("dm_hdlc", fcol(191), 24'h00_0000);
         chk("dm_take", 24'(ntake), 24'h00_0060);
      end
      hdlc <= '0;
   endtask : t_dm
   //////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      t_regs();
      t_passthru();
      t_yellow();
      t_j1();
      t_invert();
      t_esf();
      t_dm();
      complete_run();
   end
endmodule : tb
